// ### gp_regs_pkg.sv
// Package for the general and pointer register block.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package gp_regs_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFS_GENERAL_WORD = 8'h00;
    localparam logic [7:0] OFS_GENERAL_LOW_BYTE = 8'h04;
    localparam logic [7:0] OFS_FRAME_BASE = 8'h08;
    localparam logic [7:0] OFS_GENERAL_BYTE_SWAP = 8'h0C;
    localparam logic [7:0] OFS_GENERAL_HIGH_BYTE = 8'h10;
    localparam logic [7:0] OFS_GENERAL_LOW_SIGN_EXT = 8'h14;
    localparam logic [7:0] OFS_FRAME_POINTER = 8'h18;
    localparam logic [7:0] OFS_DATA_POINTER_ZERO = 8'h1C;
    localparam logic [7:0] OFS_DATA_POINTER_ONE = 8'h20;
    localparam logic [7:0] OFS_FRAME_OFFSET = 8'h24;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Field positions of the general word
    localparam int LOW_BYTE_MSB = 7;
    localparam int HIGH_BYTE_LSB = 8;

    // Pointer select codes of a memory access
    localparam logic [1:0] SEL_DP0 = 2'h0;
    localparam logic [1:0] SEL_DP1 = 2'h1;
    localparam logic [1:0] SEL_FP = 2'h2;

    // Step codes of a memory access
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;

    // One data memory access through a pointer
    typedef struct packed {
        logic valid;
        logic is_write;
        logic [1:0] sel;
        logic [1:0] step;
    } ptr_access_t;
endpackage

// ### gp_regs.sv
// General word register with byte views, frame pointer and two
// data pointers, reached over an Avalon-MM slave with waitrequest.
// Assumes the core issues pointer accesses on clk_sys as pulses.
//
// What this block does
// - All 16-bit registers and views reset to zero
// - Low and high byte registers reset to zero
// - Low byte write lands in word bits 7:0
// - High byte write lands in word bits 15:8
// - Low byte read returns word bits 7:0
// - High byte read returns word bits 15:8
// - Swap view exchanges the two word bytes
// - Sign view extends word bit 7 upward
// - Frame pointer is unsigned base plus offset
// - Offset stepping never touches the frame base
// - Frame pointer view reads the present sum
// - Pointer zero steps after reads, before writes
// - Pointer one steps after reads, before writes
// - Eight-bit offset steps post-read, pre-write
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module gp_regs
    import gp_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire ptr_access_t ptr_req,
    output logic [15:0] mem_addr
);
    logic ack_reg; // Second cycle of a bus request
    logic [31:0] readdata_reg; // Read answer, loaded in first cycle
    logic [15:0] general_word_reg; // General word
    logic [15:0] frame_base_reg; // Frame base
    logic [7:0] frame_offset_reg; // Frame offset
    logic [15:0] data_pointer_zero_reg; // Pointer zero
    logic [15:0] data_pointer_one_reg; // Pointer one
    logic [15:0] mem_addr_reg; // Address of the last access
    logic bus_wr; // Write taken at this edge
    logic bus_rd; // Read answered at this edge
    logic [15:0] wdata16; // Low half of write data
    logic [15:0] general_byte_swap; // Swap view
    logic [15:0] general_low_sign_extended; // Sign view
    logic [15:0] frame_pointer; // Base plus offset
    logic [7:0] offset_stepped; // Offset after its step
    logic [15:0] fp_stepped; // Frame pointer with stepped offset
    logic [15:0] dp0_stepped; // Pointer zero after its step
    logic [15:0] dp1_stepped; // Pointer one after its step
    logic acc_dp0; // Access through pointer zero
    logic acc_dp1; // Access through pointer one
    logic acc_fp; // Access through frame pointer
    logic [31:0] read_mux; // Read value by address

    // Increment, decrement or hold a 16-bit pointer
    function automatic logic [15:0] step16(input logic [15:0] v, input logic [1:0] s);
        logic [15:0] r;
        r = v;
        if (s == STEP_INC) begin
            r = v + 16'h0001;
        end else if (s == STEP_DEC) begin
            r = v - 16'h0001;
        end
        return r;
    endfunction

    // Merge the enabled byte lanes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // One wait state on every request; the answer comes on the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign bus_wr = avs_write & ack_reg;
    assign bus_rd = avs_read & ack_reg;
    assign wdata16 = avs_writedata[15:0];
    assign avs_readdata = readdata_reg;
    assign mem_addr = mem_addr_reg;

    // Derived views, always current with the word, base and offset
    assign general_byte_swap = {general_word_reg[LOW_BYTE_MSB:0],
                                general_word_reg[15:HIGH_BYTE_LSB]};
    assign general_low_sign_extended = {{8{general_word_reg[LOW_BYTE_MSB]}},
                                        general_word_reg[LOW_BYTE_MSB:0]};
    assign frame_pointer = frame_base_reg + {8'h00, frame_offset_reg};

    // Which pointer the core is using this cycle
    assign acc_dp0 = ptr_req.valid && (ptr_req.sel == SEL_DP0);
    assign acc_dp1 = ptr_req.valid && (ptr_req.sel == SEL_DP1);
    // Reserved select code falls back to the frame pointer
    assign acc_fp = ptr_req.valid && ptr_req.sel[1];
    assign dp0_stepped = step16(data_pointer_zero_reg, ptr_req.step);
    assign dp1_stepped = step16(data_pointer_one_reg, ptr_req.step);
    // Offset wraps in 8 bits; the carry is dropped, not passed to base
    assign offset_stepped = 8'(step16({8'h00, frame_offset_reg}, ptr_req.step));
    assign fp_stepped = frame_base_reg + {8'h00, offset_stepped};

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        read_mux = 32'h0000_0000;
        case (avs_address)
            OFS_GENERAL_WORD: read_mux[15:0] = general_word_reg;
            OFS_GENERAL_LOW_BYTE: read_mux[7:0] = general_word_reg[7:0];
            OFS_GENERAL_HIGH_BYTE: read_mux[7:0] = general_word_reg[15:8];
            OFS_GENERAL_BYTE_SWAP: read_mux[15:0] = general_byte_swap;
            OFS_GENERAL_LOW_SIGN_EXT: read_mux[15:0] = general_low_sign_extended;
            OFS_FRAME_BASE: read_mux[15:0] = frame_base_reg;
            OFS_FRAME_OFFSET: read_mux[7:0] = frame_offset_reg;
            OFS_FRAME_POINTER: read_mux[15:0] = frame_pointer;
            OFS_DATA_POINTER_ZERO: read_mux[15:0] = data_pointer_zero_reg;
            OFS_DATA_POINTER_ONE: read_mux[15:0] = data_pointer_one_reg;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // Bus handshake; read data captured in the waited cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read && !ack_reg) begin
                readdata_reg <= read_mux;
            end
        end
    end

    // General word: full, low byte and high byte writes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            general_word_reg <= RST_WORD;
        end else if (bus_wr) begin
            case (avs_address)
                OFS_GENERAL_WORD: begin
                    general_word_reg <= merge16(general_word_reg, wdata16,
                                                avs_byteenable[1:0]);
                end
                OFS_GENERAL_LOW_BYTE: begin
                    // Only the low byte moves, the high byte is kept
                    if (avs_byteenable[0]) begin
                        general_word_reg[7:0] <= wdata16[7:0];
                    end
                end
                OFS_GENERAL_HIGH_BYTE: begin
                    if (avs_byteenable[0]) begin
                        general_word_reg[15:8] <= wdata16[7:0];
                    end
                end
                // Writes to the read-only views fall here and do nothing
                default: general_word_reg <= general_word_reg;
            endcase
        end
    end

    // Frame base: bus writes only, never the offset's carry
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frame_base_reg <= RST_WORD;
        end else if (bus_wr && avs_address == OFS_FRAME_BASE) begin
            frame_base_reg <= merge16(frame_base_reg, wdata16, avs_byteenable[1:0]);
        end
    end

    // Frame offset: bus write wins over a step in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frame_offset_reg <= RST_BYTE;
        end else if (bus_wr && avs_address == OFS_FRAME_OFFSET) begin
            if (avs_byteenable[0]) begin
                frame_offset_reg <= wdata16[7:0];
            end
        end else if (acc_fp) begin
            frame_offset_reg <= offset_stepped;
        end
    end

    // Pointer zero: bus write wins over a step in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_pointer_zero_reg <= RST_WORD;
        end else if (bus_wr && avs_address == OFS_DATA_POINTER_ZERO) begin
            data_pointer_zero_reg <= merge16(data_pointer_zero_reg, wdata16,
                                             avs_byteenable[1:0]);
        end else if (acc_dp0) begin
            data_pointer_zero_reg <= dp0_stepped;
        end
    end

    // Pointer one: same policy as pointer zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_pointer_one_reg <= RST_WORD;
        end else if (bus_wr && avs_address == OFS_DATA_POINTER_ONE) begin
            data_pointer_one_reg <= merge16(data_pointer_one_reg, wdata16,
                                            avs_byteenable[1:0]);
        end else if (acc_dp1) begin
            data_pointer_one_reg <= dp1_stepped;
        end
    end

    // Access address: reads use the old value, writes the stepped one
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr_reg <= RST_WORD;
        end else if (acc_dp0) begin
            mem_addr_reg <= ptr_req.is_write ? dp0_stepped : data_pointer_zero_reg;
        end else if (acc_dp1) begin
            mem_addr_reg <= ptr_req.is_write ? dp1_stepped : data_pointer_one_reg;
        end else if (acc_fp) begin
            mem_addr_reg <= ptr_req.is_write ? fp_stepped : frame_pointer;
        end
    end

    // Checks on reset, views and pointer stepping
    // Registers are unknown before the first reset edge, so the check
    // is held off while reset is low and looks at the first edge after release
    property p_reset_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        !$past(reset_n) |-> (general_word_reg == RST_WORD
            && frame_base_reg == RST_WORD && data_pointer_zero_reg == RST_WORD
            && data_pointer_one_reg == RST_WORD && frame_pointer == RST_WORD);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("register not zero after reset");

    property p_bytes_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        !$past(reset_n) |-> general_word_reg[7:0] == RST_BYTE
            && general_word_reg[15:8] == RST_BYTE;
    endproperty
    a_bytes_zero: assert property (p_bytes_zero)
        else $error("byte view not zero after reset");

    property p_low_write;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_wr && avs_address == OFS_GENERAL_LOW_BYTE && avs_byteenable[0] |=>
            general_word_reg[7:0] == $past(wdata16[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write lost");

    property p_high_write;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_wr && avs_address == OFS_GENERAL_HIGH_BYTE && avs_byteenable[0] |=>
            general_word_reg[15:8] == $past(wdata16[7:0])
            && general_word_reg[7:0] == $past(general_word_reg[7:0]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high byte write wrong");

    property p_low_read;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_rd && avs_address == OFS_GENERAL_LOW_BYTE |->
            avs_readdata == {24'h000000, $past(general_word_reg[7:0])};
    endproperty
    a_low_read: assert property (p_low_read) else $error("low byte read wrong");

    property p_high_read;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_rd && avs_address == OFS_GENERAL_HIGH_BYTE |->
            avs_readdata == {24'h000000, $past(general_word_reg[15:8])};
    endproperty
    a_high_read: assert property (p_high_read) else $error("high byte read wrong");

    property p_swap_read;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_rd && avs_address == OFS_GENERAL_BYTE_SWAP |->
            avs_readdata[15:8] == $past(general_word_reg[7:0])
            && avs_readdata[7:0] == $past(general_word_reg[15:8]);
    endproperty
    a_swap_read: assert property (p_swap_read) else $error("swap view wrong");

    property p_sign_read;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_rd && avs_address == OFS_GENERAL_LOW_SIGN_EXT |->
            avs_readdata[15:8] == {8{$past(general_word_reg[7])}}
            && avs_readdata[7:0] == $past(general_word_reg[7:0]);
    endproperty
    a_sign_read: assert property (p_sign_read) else $error("sign view wrong");

    property p_fp_read;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_rd && avs_address == OFS_FRAME_POINTER |-> avs_readdata[15:0] ==
            16'($past(frame_base_reg) + {8'h00, $past(frame_offset_reg)});
    endproperty
    a_fp_read: assert property (p_fp_read) else $error("frame pointer read wrong");

    property p_base_kept;
        @(posedge clk_sys) disable iff (!reset_n)
        acc_fp && !bus_wr |=> $stable(frame_base_reg);
    endproperty
    a_base_kept: assert property (p_base_kept) else $error("offset step moved base");

    property p_dp0_post_read;
        @(posedge clk_sys) disable iff (!reset_n)
        acc_dp0 && !ptr_req.is_write && ptr_req.step == STEP_INC && !bus_wr |=>
            mem_addr == $past(data_pointer_zero_reg)
            && data_pointer_zero_reg == 16'($past(data_pointer_zero_reg) + 16'h0001);
    endproperty
    a_dp0_post_read: assert property (p_dp0_post_read)
        else $error("pointer zero post step");

    property p_dp1_pre_write;
        @(posedge clk_sys) disable iff (!reset_n)
        acc_dp1 && ptr_req.is_write && ptr_req.step == STEP_DEC && !bus_wr |=>
            data_pointer_one_reg == 16'($past(data_pointer_one_reg) - 16'h0001)
            && mem_addr == data_pointer_one_reg;
    endproperty
    a_dp1_pre_write: assert property (p_dp1_pre_write) else $error("pointer one pre step");

    property p_offs_step;
        @(posedge clk_sys) disable iff (!reset_n)
        acc_fp && !ptr_req.is_write && ptr_req.step == STEP_INC && !bus_wr |=>
            frame_offset_reg == 8'($past(frame_offset_reg) + 8'h01)
            && mem_addr == $past(frame_pointer);
    endproperty
    a_offs_step: assert property (p_offs_step) else $error("offset post step wrong");

    property p_view_write;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_wr && (avs_address == OFS_GENERAL_BYTE_SWAP
            || avs_address == OFS_GENERAL_LOW_SIGN_EXT) |=> $stable(general_word_reg);
    endproperty
    a_view_write: assert property (p_view_write) else $error("view write had effect");

    // Main scenarios
    c_low_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
        bus_wr && avs_address == OFS_GENERAL_LOW_BYTE);
    c_fp_wrap: cover property (@(posedge clk_sys) disable iff (!reset_n)
        acc_fp && frame_offset_reg == 8'hFF && ptr_req.step == STEP_INC);
    c_dp0_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
        acc_dp0 && ptr_req.is_write);
endmodule

// ### gp_regs_test.sv
// Self-checking bench for the general and pointer register block.
// Assumes one Avalon-MM master (this bench) and pointer pulses from it.
`timescale 1ns/100ps
module gp_regs_test;
    import gp_regs_pkg::*;
    logic clk_sys = 1'b0; // 25 MHz core clock
    logic reset_n = 1'b0; // Asynchronous reset, active low
    logic [7:0] avs_address = 8'h00; // Bus request fields
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata; // Bus answer
    logic avs_waitrequest;
    ptr_access_t ptr_req = '0; // Pointer access pulse
    logic [15:0] mem_addr; // Address of the last access
    int n_errors = 0; // Mismatches seen
    int checked = 0; // Comparisons made
    int cycles = 0; // Timeout counter
    logic [15:0] lfsr = 16'h51C6; // Random source, seeded with 20934
    logic [15:0] gw, fb, dp0, dp1, ma; // Model of the 16-bit state
    logic [7:0] fo; // Model of the frame offset
    logic [7:0] addr_tab [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'hFC}; // Last two unmapped

    gp_regs gp_regs_i (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ptr_req(ptr_req),
        .mem_addr(mem_addr)
    );

    // Free-running clock, 40 ns period
    always #20 clk_sys = ~clk_sys;

    // Cut a hang short; the whole run needs well under this
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    // Verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Single comparison point for every result
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Step the random source
    function automatic void rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    endfunction

    // Lane merge: lane 0 is the low byte, lane 1 the high byte
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
        input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Expected read answer from the model
    function automatic logic [31:0] exp_read(input logic [7:0] a);
        logic [15:0] fp;
        fp = fb + {8'h00, fo};
        case (a)
            OFS_GENERAL_WORD: return {16'h0000, gw};
            OFS_GENERAL_LOW_BYTE: return {24'h000000, gw[7:0]};
            OFS_GENERAL_HIGH_BYTE: return {24'h000000, gw[15:8]};
            OFS_GENERAL_BYTE_SWAP: return {16'h0000, gw[7:0], gw[15:8]};
            OFS_GENERAL_LOW_SIGN_EXT: return {16'h0000, {8{gw[7]}}, gw[7:0]};
            OFS_FRAME_BASE: return {16'h0000, fb};
            OFS_FRAME_POINTER: return {16'h0000, fp};
            OFS_DATA_POINTER_ZERO: return {16'h0000, dp0};
            OFS_DATA_POINTER_ONE: return {16'h0000, dp1};
            OFS_FRAME_OFFSET: return {24'h000000, fo};
            default: return 32'h00000000; // Unmapped reads as zero
        endcase
    endfunction

    // One bus transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Bus write mirrored into the model; views and holes ignore writes
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] rd;
        bus(1'b1, a, wd, be, rd);
        case (a)
            OFS_GENERAL_WORD: gw = merge(gw, wd[15:0], be);
            OFS_GENERAL_LOW_BYTE: if (be[0]) gw[7:0] = wd[7:0];
            OFS_GENERAL_HIGH_BYTE: if (be[0]) gw[15:8] = wd[7:0];
            OFS_FRAME_BASE: fb = merge(fb, wd[15:0], be);
            OFS_DATA_POINTER_ZERO: dp0 = merge(dp0, wd[15:0], be);
            OFS_DATA_POINTER_ONE: dp1 = merge(dp1, wd[15:0], be);
            OFS_FRAME_OFFSET: if (be[0]) fo = wd[7:0];
            default: ;
        endcase
    endtask

    // Read every register and two holes, compare with the model
    task automatic read_all();
        logic [31:0] rd;
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, addr_tab[i], 32'h00000000, 4'h0, rd);
            check("readdata", rd, exp_read(addr_tab[i]));
        end
    endtask

    // Data pointer stepping: after a read, before a write
    task automatic step_ptr(inout logic [15:0] p, input logic w, input logic [15:0] d);
        if (w) p = p + d;
        ma = p;
        if (!w) p = p + d;
    endtask

    // One pointer access pulse, then the address is compared
    task automatic ptr(input logic w, input logic [1:0] s, input logic [1:0] st);
        logic [15:0] d;
        d = (st == STEP_INC) ? 16'h0001 : ((st == STEP_DEC) ? 16'hFFFF : 16'h0000);
        @(posedge clk_sys);
        ptr_req <= '{1'b1, w, s, st};
        @(posedge clk_sys);
        ptr_req <= '0;
        if (s == SEL_DP0) step_ptr(dp0, w, d);
        else if (s == SEL_DP1) step_ptr(dp1, w, d);
        else begin
            // Offset wraps in 8 bits and never carries into the base
            if (w) fo = fo + d[7:0];
            ma = fb + {8'h00, fo};
            if (!w) fo = fo + d[7:0];
        end
        @(negedge clk_sys);
        check("mem_addr", {16'h0000, mem_addr}, {16'h0000, ma});
    endtask

    // Reset held for 8 cycles; model cleared alongside
    task automatic do_reset();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        {gw, fb, dp0, dp1, ma, fo} = '0;
        @(negedge clk_sys);
        check("mem_addr", {16'h0000, mem_addr}, 32'h00000000);
    endtask

    // Main sequence
    initial begin
        do_reset();
        read_all();
        // Random writes over all places, views and holes included
        for (int i = 0; i < 60; i++) begin
            rnd();
            wr_reg(addr_tab[lfsr[7:0] % 12], {lfsr, lfsr ^ 16'hA5C3}, lfsr[11:8]);
            read_all();
        end
        // Offset carry and borrow must leave the base alone
        wr_reg(OFS_FRAME_BASE, 32'h0000FFF0, 4'h3);
        wr_reg(OFS_FRAME_OFFSET, 32'h000000FF, 4'h1);
        ptr(1'b0, SEL_FP, STEP_INC);
        ptr(1'b1, SEL_FP, STEP_DEC);
        read_all();
        // Random pointer traffic with occasional reloads
        for (int i = 0; i < 80; i++) begin
            rnd();
            if (lfsr[15:14] == 2'h0) wr_reg(addr_tab[7 + (lfsr[9:8] % 3)], {16'h0000, lfsr}, 4'h3);
            rnd();
            ptr(lfsr[4], lfsr[1:0], lfsr[3:2]);
            read_all();
        end
        // Reset in mid-run clears everything again
        do_reset();
        read_all();
        close_out();
    end
endmodule
